//--- rtl/cpf_pkg.sv
// Purpose: Shared constants and types for the cell protection fault arbiter.
// Assumes: 25 MHz core clock; delays given in ms or us and turned into cycle counts here.
// Notes:   Long counts are also top-level parameters so that a simulation can shorten them.
package cpf_pkg;

  // Clock rate in kHz
  localparam int unsigned CPF_CLK_KHZ      = 25000;

  // Counter-timed delays, in milliseconds
  localparam int unsigned CPF_OVC_DET_MS   = 1000;
  localparam int unsigned CPF_OVC_REL_MS   = 16;
  localparam int unsigned CPF_OVD_DET_MS   = 125;
  localparam int unsigned CPF_OVD_REL_MS   = 16;
  localparam int unsigned CPF_OCI_DET_MS   = 10;
  localparam int unsigned CPF_OCI_REL_MS   = 1;
  localparam int unsigned CPF_XCH_DET_MS   = 16;
  localparam int unsigned CPF_XCH_REL_MS   = 16;

  // Cycle counts of the counter-timed delays
  localparam int unsigned CPF_OVC_DET_CYC  = CPF_OVC_DET_MS * CPF_CLK_KHZ;
  localparam int unsigned CPF_OVC_REL_CYC  = CPF_OVC_REL_MS * CPF_CLK_KHZ;
  localparam int unsigned CPF_OVD_DET_CYC  = CPF_OVD_DET_MS * CPF_CLK_KHZ;
  localparam int unsigned CPF_OVD_REL_CYC  = CPF_OVD_REL_MS * CPF_CLK_KHZ;
  localparam int unsigned CPF_OCI_DET_CYC  = CPF_OCI_DET_MS * CPF_CLK_KHZ;
  localparam int unsigned CPF_OCI_REL_CYC  = CPF_OCI_REL_MS * CPF_CLK_KHZ;
  localparam int unsigned CPF_XCH_DET_CYC  = CPF_XCH_DET_MS * CPF_CLK_KHZ;
  localparam int unsigned CPF_XCH_REL_CYC  = CPF_XCH_REL_MS * CPF_CLK_KHZ;

  // Short-circuit delay is fixed, not taken from the shortened counter; least time, rounded up
  localparam int unsigned CPF_SC_DET_US    = 100;
  localparam int unsigned CPF_SC_DET_CYC   = (CPF_SC_DET_US * CPF_CLK_KHZ + 999) / 1000;

  // Test shortening divides every counter delay by 2**shift
  localparam int unsigned CPF_TEST_SHIFT   = 6;

  // Delay counter width
  localparam int unsigned CPF_CW           = 26;

  // Timer slots
  localparam int unsigned CPF_NT           = 9;
  localparam int unsigned CPF_T_OVC_DET    = 0;
  localparam int unsigned CPF_T_OVC_REL    = 1;
  localparam int unsigned CPF_T_OVD_DET    = 2;
  localparam int unsigned CPF_T_OVD_REL    = 3;
  localparam int unsigned CPF_T_OCI_DET    = 4;
  localparam int unsigned CPF_T_OCI_REL    = 5;
  localparam int unsigned CPF_T_SC_DET     = 6;
  localparam int unsigned CPF_T_XCH_DET    = 7;
  localparam int unsigned CPF_T_XCH_REL    = 8;

  // Register byte offsets
  localparam logic [7:0]  CPF_STATUS_OFS   = 8'h00;
  localparam logic [7:0]  CPF_CTRL_OFS     = 8'h04;
  localparam logic [7:0]  CPF_PEND_OFS     = 8'h08;
  localparam logic [7:0]  CPF_FIRST_OFS    = 8'h0C;

  // Control field positions and reset value
  localparam int unsigned CPF_CTRL_TEST_B  = 0;
  localparam int unsigned CPF_CTRL_CLRF_B  = 1;
  localparam logic [31:0] CPF_CTRL_RST     = 32'h0000_0000;

  // Sense-node pull selection
  typedef enum logic [1:0] {
    CPF_PULL_NONE = 2'b00,
    CPF_PULL_VDD  = 2'b01,
    CPF_PULL_VSS  = 2'b10
  } cpf_pull_t;

  // First detection made from a quiet state
  typedef enum logic [2:0] {
    CPF_FIRST_NONE = 3'b000,
    CPF_FIRST_OVC  = 3'b001,
    CPF_FIRST_OVD  = 3'b010,
    CPF_FIRST_OCI  = 3'b011,
    CPF_FIRST_SC   = 3'b100,
    CPF_FIRST_XCH  = 3'b101
  } cpf_first_t;

  // Comparator levels from the analog front end
  typedef struct packed {
    logic chg;   // Charger connected (standby release)
    logic xch;   // Excessive charger voltage
    logic sc;    // Short circuit
    logic oci;   // Over-current
    logic ovd;   // Over-discharge
    logic ovc;   // Over-charge
  } cpf_cmp_t;

  // Detection status word
  typedef struct packed {
    logic      test;
    cpf_pull_t pull;
    logic      standby;
    logic      xch;
    logic      sc;
    logic      oci;
    logic      ovd;
    logic      ovc;
  } cpf_stat_t;

endpackage

//--- rtl/cpf_delay_timer.sv
// Purpose: One delay counter; counts cycles while its condition holds.
// Assumes: tc_i is at least one; tc_i may change only while run_i is low.
// Notes:   Dropping run_i clears the count at once, so a lost condition restarts the delay.
`timescale 1ns/100ps
module cpf_delay_timer
  import cpf_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                ce_i,
  input  wire logic                run_i,
  input  wire logic [CPF_CW-1:0]   tc_i,
  output logic                     done_o
);

  logic [CPF_CW-1:0] cnt;
  logic [CPF_CW-1:0] cnt_inc;
  logic              at_end;

  // Next count and terminal compare
  assign cnt_inc = cnt + {{(CPF_CW-1){1'b0}}, 1'b1};
  assign at_end  = (cnt_inc >= tc_i);

  // Count while running; done stays high until the condition goes away
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt    <= '0;
      done_o <= 1'b0;
    end else if (ce_i) begin
      if (!run_i) begin
        cnt    <= '0;
        done_o <= 1'b0;
      end else if (!done_o) begin
        if (at_end) begin
          done_o <= 1'b1;
        end else begin
          cnt <= cnt_inc;
        end
      end
    end
  end

endmodule

//--- rtl/cpf_arbiter.sv
// Purpose: Fault arbiter of a two-cell protection device with a Wishbone register port.
// Assumes: Comparator flags and the test pin are asynchronous and are synchronised here.
// Notes:   Gate outputs are high when the switch is on; pulls are one-hot or both low.
//
// Added by the designer: the register addresses and register access over Wishbone.
`timescale 1ns/100ps
module cpf_arbiter
  import cpf_pkg::*;
#(
  parameter int unsigned OVC_DET_CYC = CPF_OVC_DET_CYC,
  parameter int unsigned OVC_REL_CYC = CPF_OVC_REL_CYC,
  parameter int unsigned OVD_DET_CYC = CPF_OVD_DET_CYC,
  parameter int unsigned OVD_REL_CYC = CPF_OVD_REL_CYC,
  parameter int unsigned OCI_DET_CYC = CPF_OCI_DET_CYC,
  parameter int unsigned OCI_REL_CYC = CPF_OCI_REL_CYC,
  parameter int unsigned XCH_DET_CYC = CPF_XCH_DET_CYC,
  parameter int unsigned XCH_REL_CYC = CPF_XCH_REL_CYC
)(
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  input  wire cpf_cmp_t     cmp_i,
  input  wire logic         test_shorten_i,
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [7:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic [31:0]       wb_dat_o,
  output logic              wb_ack_o,
  output logic              chg_gate_o,
  output logic              dsc_gate_o,
  output logic              pull_vdd_o,
  output logic              pull_vss_o,
  output logic              standby_o
);

  // Synchroniser stages
  cpf_cmp_t          cmp_m;
  cpf_cmp_t          cmp_s;
  logic              test_m;
  logic              test_s;

  // Detection state
  logic              ovc_det;
  logic              ovd_det;
  logic              oci_det;
  logic              sc_det;
  logic              xch_det;
  logic              standby;
  logic              clr_first;
  cpf_pull_t         pull;
  cpf_first_t        first;
  logic [31:0]       ctrl;

  // Timer connections
  logic [CPF_NT-1:0] run;
  logic [CPF_NT-1:0] done;
  logic [CPF_CW-1:0] tc_norm [CPF_NT];
  logic [CPF_CW-1:0] tc_sel  [CPF_NT];

  // Next values
  logic              next_ovc_det;
  logic              next_ovd_det;
  logic              next_oci_det;
  logic              next_sc_det;
  logic              next_xch_det;
  logic              next_standby;
  cpf_pull_t         next_pull;
  cpf_first_t        next_first;
  logic              test_act;
  logic              dsc_fault;
  logic              any_det;

  // Bus decode
  logic              wb_req;
  logic              hit_status;
  logic              hit_ctrl;
  logic              hit_pend;
  logic              hit_first;
  logic              ctrl_wr;
  cpf_stat_t         stat;
  logic [31:0]       rd_mux;

  // Two-flop synchronisers for pin-level inputs
  // Nothing reads the first stage directly
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp_m  <= '0;
      cmp_s  <= '0;
      test_m <= 1'b0;
      test_s <= 1'b0;
    end else if (ce_i) begin
      cmp_m  <= cmp_i;
      cmp_s  <= cmp_m;
      test_m <= test_shorten_i;
      test_s <= test_m;
    end
  end

  // Shortening from the pin or from software; an open pin reads low
  assign test_act = test_s | ctrl[CPF_CTRL_TEST_B];

  // Full-length terminal counts
  assign tc_norm[CPF_T_OVC_DET] = CPF_CW'(OVC_DET_CYC);
  assign tc_norm[CPF_T_OVC_REL] = CPF_CW'(OVC_REL_CYC);
  assign tc_norm[CPF_T_OVD_DET] = CPF_CW'(OVD_DET_CYC);
  assign tc_norm[CPF_T_OVD_REL] = CPF_CW'(OVD_REL_CYC);
  assign tc_norm[CPF_T_OCI_DET] = CPF_CW'(OCI_DET_CYC);
  assign tc_norm[CPF_T_OCI_REL] = CPF_CW'(OCI_REL_CYC);
  assign tc_norm[CPF_T_SC_DET]  = CPF_CW'(CPF_SC_DET_CYC);
  assign tc_norm[CPF_T_XCH_DET] = CPF_CW'(XCH_DET_CYC);
  assign tc_norm[CPF_T_XCH_REL] = CPF_CW'(XCH_REL_CYC);

  // Discharge-side faults and overall activity
  // Charge-side states are no discharge fault
  assign dsc_fault = ovd_det | oci_det | sc_det;
  assign any_det   = ovc_det | dsc_fault | xch_det;

  // Run conditions; standby stops over-charge, over-current and excessive-charger detection, and over-discharge release without charger
  // A blocked timer loses its count, so an
  // aborted detection starts again from zero.
  // Over-discharge yields only while the
  // over-charge delay itself is running.
  assign run[CPF_T_OVC_DET] = cmp_s.ovc & ~ovc_det & ~standby;
  assign run[CPF_T_OVC_REL] = ovc_det & ~cmp_s.ovc;
  assign run[CPF_T_OVD_DET] = cmp_s.ovd & ~ovd_det & ~run[CPF_T_OVC_DET];
  assign run[CPF_T_OVD_REL] = ovd_det & ~cmp_s.ovd & (~standby | cmp_s.chg);
  assign run[CPF_T_OCI_DET] = cmp_s.oci & ~oci_det & ~ovc_det & ~ovd_det & ~standby;
  assign run[CPF_T_OCI_REL] = (oci_det | sc_det) & ~cmp_s.oci & ~cmp_s.sc;
  assign run[CPF_T_SC_DET]  = cmp_s.sc & ~sc_det;
  assign run[CPF_T_XCH_DET] = cmp_s.xch & ~xch_det & ~dsc_fault & ~standby;
  assign run[CPF_T_XCH_REL] = xch_det & ~cmp_s.xch;

  // Terminal count per timer, shortened in test mode except the fixed short-circuit delay
  // A floor of one cycle keeps a shortened
  // delay from vanishing.
  genvar gi;
  generate
    for (gi = 0; gi < CPF_NT; gi++) begin : g_tmr
      if (gi == CPF_T_SC_DET) begin : g_fixed
        assign tc_sel[gi] = tc_norm[gi];
      end else begin : g_cnt
        logic [CPF_CW-1:0] tc_short;
        assign tc_short   = tc_norm[gi] >> CPF_TEST_SHIFT;
        assign tc_sel[gi] = !test_act ? tc_norm[gi] :
                            (tc_short == '0) ? {{(CPF_CW-1){1'b0}}, 1'b1} : tc_short;
      end
      cpf_delay_timer u_tmr (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .ce_i   (ce_i),
        .run_i  (run[gi]),
        .tc_i   (tc_sel[gi]),
        .done_o (done[gi])
      );
    end
  endgenerate

  // Over-charge state: set by its delay, cleared by its release delay
  // Flags set one cycle after their timer;
  // the pins follow the next values.
  assign next_ovc_det = ovc_det ? ~done[CPF_T_OVC_REL] : done[CPF_T_OVC_DET];

  // Over-discharge state
  assign next_ovd_det = ovd_det ? ~done[CPF_T_OVD_REL] : done[CPF_T_OVD_DET];

  // Over-current state; a competing state that arrives first keeps it from completing
  assign next_oci_det = oci_det ? ~done[CPF_T_OCI_REL] : done[CPF_T_OCI_DET];

  // Short-circuit state shares the over-current release
  // No release timer of its own: it waits for
  // both current comparators to drop.
  assign next_sc_det  = sc_det ? ~done[CPF_T_OCI_REL] : done[CPF_T_SC_DET];

  // Excessive-charger state
  assign next_xch_det = xch_det ? ~done[CPF_T_XCH_REL] : done[CPF_T_XCH_DET];

  // Standby only when over-discharge completes without over-charge standing
  // Decided when over-discharge completes; a
  // standing over-charge keeps the part awake.
  assign next_standby = standby ? next_ovd_det
                                : (done[CPF_T_OVD_DET] & ~ovd_det & ~ovc_det);

  // Sense-node pull selection from the standing states
  // Over-discharge outranks over-current, so
  // an empty cell is lifted even under load.
  always_comb begin
    next_pull = CPF_PULL_NONE;
    case ({next_ovd_det, next_oci_det | next_sc_det})
      2'b10,
      2'b11: begin
        next_pull = CPF_PULL_VDD;
      end
      2'b01: begin
        next_pull = CPF_PULL_VSS;
      end
      2'b00: begin
        next_pull = CPF_PULL_NONE;
      end
      default: begin
        next_pull = CPF_PULL_NONE;
      end
    endcase
  end

  // Record which detection came first from a quiet state
  // Later overlaps leave the record alone
  always_comb begin
    next_first = first;
    if (clr_first && !any_det) begin
      next_first = CPF_FIRST_NONE;
    end else if (first == CPF_FIRST_NONE && !any_det) begin
      case (1'b1)
        next_ovc_det: next_first = CPF_FIRST_OVC;
        next_ovd_det: next_first = CPF_FIRST_OVD;
        next_sc_det:  next_first = CPF_FIRST_SC;
        next_oci_det: next_first = CPF_FIRST_OCI;
        next_xch_det: next_first = CPF_FIRST_XCH;
        default:      next_first = CPF_FIRST_NONE;
      endcase
    end
  end

  // Detection state registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovc_det <= 1'b0;
      ovd_det <= 1'b0;
      oci_det <= 1'b0;
      sc_det  <= 1'b0;
      xch_det <= 1'b0;
      standby <= 1'b0;
      pull    <= CPF_PULL_NONE;
      first   <= CPF_FIRST_NONE;
    end else if (ce_i) begin
      ovc_det <= next_ovc_det;
      ovd_det <= next_ovd_det;
      oci_det <= next_oci_det;
      sc_det  <= next_sc_det;
      xch_det <= next_xch_det;
      standby <= next_standby;
      pull    <= next_pull;
      first   <= next_first;
    end
  end

  // Pin outputs, registered from the next state so they track it without a second lag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chg_gate_o <= 1'b1;
      dsc_gate_o <= 1'b1;
      pull_vdd_o <= 1'b0;
      pull_vss_o <= 1'b0;
      standby_o  <= 1'b0;
    end else if (ce_i) begin
      chg_gate_o <= ~(next_ovc_det | next_xch_det);
      dsc_gate_o <= ~(next_ovd_det | next_oci_det | next_sc_det);
      pull_vdd_o <= (next_pull == CPF_PULL_VDD);
      pull_vss_o <= (next_pull == CPF_PULL_VSS);
      standby_o  <= next_standby;
    end
  end

  // Wishbone address decode
  // Offsets compare on the full byte address
  assign wb_req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign hit_status = (wb_adr_i == CPF_STATUS_OFS);
  assign hit_ctrl   = (wb_adr_i == CPF_CTRL_OFS);
  assign hit_pend   = (wb_adr_i == CPF_PEND_OFS);
  assign hit_first  = (wb_adr_i == CPF_FIRST_OFS);
  assign ctrl_wr    = wb_req & wb_we_i & hit_ctrl & wb_sel_i[0];

  // Status word
  assign stat.ovc     = ovc_det;
  assign stat.ovd     = ovd_det;
  assign stat.oci     = oci_det;
  assign stat.sc      = sc_det;
  assign stat.xch     = xch_det;
  assign stat.standby = standby;
  assign stat.pull    = pull;
  assign stat.test    = test_act;

  // Read data selection; unmapped addresses read zero
  assign rd_mux = hit_status ? {{(32-$bits(cpf_stat_t)){1'b0}}, stat} :
                  hit_ctrl   ? ctrl :
                  hit_pend   ? {{(32-CPF_NT){1'b0}}, run} :
                  hit_first  ? {29'h0000_0000, first} :
                               32'h0000_0000;

  // Control register; the clear-first bit is a self-clearing strobe
  // Only the low byte lane updates control
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl      <= CPF_CTRL_RST;
      clr_first <= 1'b0;
    end else if (ce_i) begin
      clr_first <= ctrl_wr & wb_dat_i[CPF_CTRL_CLRF_B];
      if (ctrl_wr) begin
        ctrl[CPF_CTRL_TEST_B] <= wb_dat_i[CPF_CTRL_TEST_B];
      end
    end
  end

  // Bus answer: one wait state, ack for one cycle on any address
  // Ack low gates the request, so an stb held
  // through the ack cycle is not taken twice.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        wb_dat_o <= rd_mux;
      end
    end
  end

endmodule

//--- tb/cpf_cell_model.sv
// Purpose: Cell, charger and load model that drives the comparator levels and the test pin.
// Assumes: The bench asks for cell conditions as a comparator word.
// Notes:   Levels reach the pins one clock after they are asked for.
`timescale 1ns/100ps
module cpf_cell_model
  import cpf_pkg::*;
(
  input  wire logic     clk_i,
  input  wire cpf_cmp_t want_i,
  input  wire logic     test_req_i,
  output cpf_cmp_t      cmp_o = '0,
  output logic          test_o = 1'b0
);
  // Comparators follow the cell state; the test pin stays grounded unless asked
  always @(posedge clk_i) begin
    cmp_o  <= want_i;
    test_o <= test_req_i;
  end
endmodule

//--- tb/cpf_arbiter_properties.sv
// Purpose: Port-level checks of the fault arbiter.
// Assumes: One clock domain; clock enable drops only while no over-charge or short stands.
// Notes:   Run counters saturate; margins of a few cycles cover the synchronisers.
`timescale 1ns/100ps
module cpf_arbiter_properties
  import cpf_pkg::*;
#(
  parameter int unsigned OVC_DET_CYC = CPF_OVC_DET_CYC,
  parameter int unsigned XCH_DET_CYC = CPF_XCH_DET_CYC
)(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire cpf_cmp_t    cmp_i,
  input  wire logic        test_shorten_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic        wb_ack_o,
  input  wire logic        chg_gate_o,
  input  wire logic        dsc_gate_o,
  input  wire logic        pull_vdd_o,
  input  wire logic        pull_vss_o,
  input  wire logic        standby_o
);
  localparam int OVC_FULL  = OVC_DET_CYC + 8;
  localparam int OVC_SHRT  = ((OVC_DET_CYC >> CPF_TEST_SHIFT) > 0 ? (OVC_DET_CYC >> CPF_TEST_SHIFT) : 1) + 8;
  localparam int SC_LATE   = CPF_SC_DET_CYC + 8;
  logic [15:0] ovc_act, xch_run, sc_run;
  logic        soft_tm, tm_seen;
  // Snooped control write, test mode and saturating run counters
  wire         ctrl_wr      = wb_ack_o && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_adr_i == CPF_CTRL_OFS;
  wire         tmode        = test_shorten_i || soft_tm;
  wire  [15:0] next_ovc_act = (cmp_i.ovc && !standby_o) ? ovc_act + {15'h0000, ~&ovc_act} : 16'h0000;
  wire  [15:0] next_xch_run = cmp_i.xch ? xch_run + {15'h0000, ~&xch_run} : 16'h0000;
  wire  [15:0] next_sc_run  = cmp_i.sc ? sc_run + {15'h0000, ~&sc_run} : 16'h0000;
  // Counter registers
  always_ff @(posedge clk_i) begin
    ovc_act <= rst_i ? 16'h0000 : next_ovc_act;
    xch_run <= rst_i ? 16'h0000 : next_xch_run;
    sc_run  <= rst_i ? 16'h0000 : next_sc_run;
    soft_tm <= !rst_i && (ctrl_wr ? wb_dat_i[0] : soft_tm);
    tm_seen <= !rst_i && (tm_seen || tmode);
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  chk_ack_single: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single pulse");
  chk_ovc_full: assert property (ovc_act == OVC_FULL |-> !chg_gate_o)
    else $error("charge gate still on after full delay");
  chk_ovc_short: assert property (tmode && ovc_act == OVC_SHRT |-> !chg_gate_o)
    else $error("test mode did not shorten delay");
  chk_ovc_not_early: assert property ($fell(chg_gate_o) && !tm_seen |-> ovc_act >= OVC_DET_CYC || xch_run >= XCH_DET_CYC)
    else $error("charge gate off too early");
  chk_sc_fixed: assert property (sc_run == SC_LATE |-> !dsc_gate_o)
    else $error("short circuit not acted on");
  chk_sc_not_short: assert property ($fell(dsc_gate_o) && cmp_i.sc && !cmp_i.oci |-> sc_run >= CPF_SC_DET_CYC)
    else $error("short circuit delay shortened");
  chk_pull_single: assert property (!(pull_vdd_o && pull_vss_o))
    else $error("both pulls on");
  chk_standby_pulls: assert property (standby_o |-> pull_vdd_o && !pull_vss_o && !dsc_gate_o)
    else $error("standby without pull up and gate off");
  chk_vss_on_oc: assert property ($rose(pull_vss_o) |-> !dsc_gate_o && !standby_o && !pull_vdd_o)
    else $error("pull down without over-current state");
  chk_chg_awake: assert property ($fell(chg_gate_o) |-> !$past(standby_o))
    else $error("charge gate fell in standby");
  chk_ovc_no_pull: assert property ($fell(chg_gate_o) && !$past(pull_vdd_o) && !$past(pull_vss_o) |->
    !pull_vdd_o && !pull_vss_o)
    else $error("over-charge set a pull");
  chk_vdd_after_ovc: assert property ($rose(pull_vdd_o) && !standby_o |-> !chg_gate_o)
    else $error("pull up without standby or over-charge");
  cov_standby: cover property ($rose(standby_o));
  cov_oc_pull: cover property ($rose(pull_vss_o));
  cov_short_ovc: cover property ($fell(chg_gate_o) && tmode);
endmodule

//--- tb/cpf_arbiter_test.sv
// Purpose: Self-checking bench for the fault arbiter.
// Assumes: Short counts below; outputs seen as {chg, dsc, vdd, vss, standby}.
// Notes:   Condition changes reach the design one clock late through the cell model.
`timescale 1ns/100ps
module cpf_arbiter_test;
  import cpf_pkg::*;
  localparam int unsigned OVC_N = 128, OVD_N = 40, OCI_N = 3000, XCH_N = 30, REL_N = 20;
  localparam logic [5:0]  OVC = 6'h01, OVD = 6'h02, OCI = 6'h04, SC = 6'h08, XCH = 6'h10, CHG = 6'h20;
  localparam logic [4:0]  IDLE = 5'h18, CHG_OFF = 5'h08, VDD_ONLY = 5'h04, OC_ST = 5'h12, SB_ST = 5'h15;
  logic        clk_i = 1'b0, rst_i = 1'b1, test_req = 1'b0, ce_i = 1'b1;
  logic [5:0]  want = 6'h00;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o, rd;
  logic        wb_ack_o, chg_gate_o, dsc_gate_o, pull_vdd_o, pull_vss_o, standby_o, test_shorten_i;
  cpf_cmp_t    cmp_i;
  int          miscompares = 0, total_checks = 0;
  wire  [4:0]  outs = {chg_gate_o, dsc_gate_o, pull_vdd_o, pull_vss_o, standby_o};

  cpf_cell_model cpf_cell_model_i (.clk_i(clk_i), .want_i(want), .test_req_i(test_req), .cmp_o(cmp_i),
    .test_o(test_shorten_i));
  cpf_arbiter #(.OVC_DET_CYC(OVC_N), .OVC_REL_CYC(REL_N), .OVD_DET_CYC(OVD_N), .OVD_REL_CYC(REL_N),
    .OCI_DET_CYC(OCI_N), .OCI_REL_CYC(REL_N), .XCH_DET_CYC(XCH_N), .XCH_REL_CYC(REL_N)) cpf_arbiter_i (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cmp_i(cmp_i), .test_shorten_i(test_shorten_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .chg_gate_o(chg_gate_o),
    .dsc_gate_o(dsc_gate_o), .pull_vdd_o(pull_vdd_o), .pull_vss_o(pull_vss_o), .standby_o(standby_o));

  // 25 MHz clock
  initial begin
    forever #20 clk_i = ~clk_i;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk_out(input string what, input logic [4:0] exp);
    total_checks++;
    if (outs !== exp) begin
      miscompares++;
      $display("BAD %s expected %b seen %b", what, exp, outs);
    end
  endtask

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Classic single cycle; holds the request until ack is sampled high
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    chk_word("bus ack latency", 32'h0000_0002, n);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rdchk(input string what, input logic [7:0] adr, input logic [31:0] exp);
    wb_xfer(1'b0, adr, 32'h0000_0000);
    chk_word(what, exp, rd);
  endtask

  // Charger on, faults gone, until all outputs are back at rest
  task automatic settle;
    int n;
    n = 0;
    want <= CHG;
    do begin
      tick(1);
      n++;
    end while (outs !== IDLE && n < 8000);
    want <= 6'h00;
    tick(4);
    chk_out("idle", IDLE);
  endtask

  // Reset, registers, then overlap scenarios
  initial begin
    tick(2);
    rst_i <= 1'b0;
    tick(1);
    chk_out("reset", IDLE);
    rdchk("ctrl", CPF_CTRL_OFS, CPF_CTRL_RST);
    rdchk("unmapped", 8'h10, 32'h0000_0000);
    wb_xfer(1'b1, CPF_STATUS_OFS, 32'hFFFF_FFFF);
    rdchk("status", CPF_STATUS_OFS, 32'h0000_0000);
    want <= OVC;
    tick(40);
    want <= OVC | OCI;
    tick(OVC_N - 39);
    chk_out("ovc pending", IDLE);
    rdchk("pend both", CPF_PEND_OFS, 32'h0000_0011);
    tick(4);
    chk_out("ovc done", CHG_OFF);
    tick(OCI_N);
    chk_out("oc aborted", CHG_OFF);
    rdchk("status ovc", CPF_STATUS_OFS, 32'h0000_0001);
    rdchk("first ovc", CPF_FIRST_OFS, 32'h0000_0001);
    settle();
    wb_xfer(1'b1, CPF_CTRL_OFS, 32'h0000_0002);
    rdchk("first cleared", CPF_FIRST_OFS, 32'h0000_0000);
    for (int f = 0; f < 2; f++) begin
      want <= (f == 0) ? OVC : OVD;
      tick(10);
      want <= OVC | OVD;
      tick(OVD_N + 8);
      chk_out("ovd held off", IDLE);
      tick(OVC_N - OVD_N - ((f == 0) ? 10 : 0));
      chk_out("ovc first", CHG_OFF);
      tick(OVD_N - 8);
      chk_out("ovd restarting", CHG_OFF);
      tick(16);
      chk_out("ovd after ovc", VDD_ONLY);
      rdchk("status both", CPF_STATUS_OFS, 32'h0000_0043);
      settle();
    end
    for (int f = 0; f < 2; f++) begin
      want <= (f == 0) ? OCI : OVD;
      tick((f == 0) ? OCI_N + 8 : OVD_N + 8);
      chk_out("first fault", (f == 0) ? OC_ST : SB_ST);
      want <= OCI | OVD | XCH;
      tick(OCI_N + 8);
      chk_out("second fault", SB_ST);
      settle();
    end
    for (int t = 0; t < 2; t++) begin
      test_req <= t[0];
      tick(4);
      want <= (t == 0) ? (SC | OCI) : SC;
      tick(CPF_SC_DET_CYC - 4);
      chk_out("sc pending", IDLE);
      tick(12);
      chk_out("sc done", OC_ST);
      settle();
    end
    for (int s = 0; s < 2; s++) begin
      test_req <= (s == 0);
      wb_xfer(1'b1, CPF_CTRL_OFS, (s == 1) ? 32'h0000_0001 : 32'h0000_0000);
      rdchk("test status", CPF_STATUS_OFS, 32'h0000_0100);
      want <= OVC;
      tick((OVC_N >> 6) + 8);
      chk_out("short ovc", CHG_OFF);
      settle();
    end
    test_req <= 1'b0;
    wb_xfer(1'b1, CPF_CTRL_OFS, 32'h0000_0000);
    want <= XCH;
    tick(XCH_N - 10);
    want <= 6'h00;
    tick(3);
    want <= XCH;
    tick(XCH_N + 1);
    chk_out("xch restarted", IDLE);
    tick(7);
    chk_out("xch done", CHG_OFF);
    settle();
    want <= OVD;
    tick(20);
    ce_i <= 1'b0;
    tick(30);
    ce_i <= 1'b1;
    tick(20);
    chk_out("ovd frozen", IDLE);
    tick(8);
    chk_out("ovd after freeze", SB_ST);
    settle();
    test_done();
  end

  // Watchdog
  initial begin
    tick(60000);
    miscompares++;
    test_done();
  end
endmodule

bind cpf_arbiter cpf_arbiter_properties #(.OVC_DET_CYC(OVC_DET_CYC), .XCH_DET_CYC(XCH_DET_CYC)) cpf_arbiter_properties_i (
  .clk_i(clk_i), .rst_i(rst_i), .cmp_i(cmp_i), .test_shorten_i(test_shorten_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .chg_gate_o(chg_gate_o), .dsc_gate_o(dsc_gate_o), .pull_vdd_o(pull_vdd_o),
  .pull_vss_o(pull_vss_o), .standby_o(standby_o));
